// ===== common/cell_group_params.svh
// Register offsets, field positions, reset values and sizes of the logic cell group.
`ifndef CELL_GROUP_PARAMS_SVH
`define CELL_GROUP_PARAMS_SVH

`define CG_SLICES        4
`define CG_LUT_INPUTS    4
`define CG_LUT_DEPTH     16
`define CG_SLICE_INPUTS  8
`define CG_CFG_WIDTH     7

`define CG_ADR_CTRL      8'h00
`define CG_ADR_STATUS    8'h04
`define CG_PAGE_CFG      4'h1
`define CG_PAGE_LUT      4'h2

`define CG_CTRL_RUN      0
`define CG_CTRL_CS_EN    1
`define CG_CTRL_RST      32'h0000_0000
`define CG_CFG_RST       7'h00
`define CG_LUT_RST       16'h0000

`define CG_RAM_LAST      2
`define CG_MEM_CTRL      2
`define CG_MEM_DATA_LO   0
`define CG_MEM_DATA_HI   1

`endif

// ===== common/cell_group_pkg.sv
// Types shared by the logic cell group.
package cell_group_pkg;

  typedef enum logic [1:0] {
    MODE_LOGIC  = 2'b00,
    MODE_RIPPLE = 2'b01,
    MODE_RAM    = 2'b10,
    MODE_ROM    = 2'b11
  } slice_mode_t;

  // Configuration of one slice; mode sits in the two lowest bits.
  typedef struct packed {
    logic [1:0]  sr_val;
    logic        sr_async;
    logic        latch_en;
    logic        clk_neg;
    slice_mode_t mode;
  } slice_cfg_t;

  // Fabric-side results of one slice.
  typedef struct packed {
    logic [1:0] f;
    logic       five_input_mux_out;
    logic       wide_function_mux_out;
  } slice_out_t;

endpackage

// ===== verilog/logic_slice_cluster.sv
// One logic cell group of four slices with a Wishbone configuration port.
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`include "cell_group_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Four slices 0..3, each two 4-input lookup tables feeding two registers.
// - Only slices 0..2 may be writable memory; slice 3 is logic, ripple or ROM.
// - Registers capture on either clock polarity, as flip-flop or level latch.
// - Local set/reset is synchronous or asynchronous; clock select and chip-select exist.
// - Each slice takes thirteen routing inputs plus carry, drives six outputs plus carry.
// - The group presents 53 inputs and 25 outputs to routing.
// - Slice 2 clock writes slices 0 and 1 memory; its set/reset is write enable.
// - Memory write address is the four lookup inputs of slice 2.
// - Write data bits 3:2 go to slice 1, bits 1:0 to slice 0.
// - Lookup results leave as bypass outputs, registered on every SYS_CLK; stored values leave separately.
// - Five-input mux output per slice; second mux forms six, seven or eight inputs.
// - Before user operation every register holds its configured set or clear value.
// - Each memory lookup table of slices 0 and 1 is sixteen by one; four bits wide.
////////////////////////////////////////////////////////////////////////////////
module logic_slice_cluster (
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output wire logic [31:0] WB_DAT_O,
  output wire logic        WB_ACK_O,
  input  wire logic [31:0] SLICE_LUT_IN,
  input  wire logic [7:0]  MULTIPURPOSE_IN,
  input  wire logic [3:0]  SLICE_CLOCK,
  input  wire logic [3:0]  SLICE_CLOCK_ENABLE,
  input  wire logic [3:0]  LOCAL_SET_RESET,
  input  wire logic        CARRY_CHAIN_IN,
  output wire logic [7:0]  LOOKUP_BYPASS_OUT,
  output wire logic [7:0]  STORED_VALUE_OUT,
  output wire logic [3:0]  FIVE_INPUT_MUX_OUT,
  output wire logic [3:0]  WIDE_FUNCTION_MUX_OUT,
  output wire logic        CARRY_CHAIN_OUT
);

  localparam int NS = `CG_SLICES;
  localparam int NI = `CG_SLICE_INPUTS;
  localparam int NK = `CG_LUT_INPUTS;

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  logic [31:0]                ctrl_ff;
  cell_group_pkg::slice_cfg_t cfg_ff [NS];
  logic [15:0]                lut_ff [NS][2];
  logic [NS-1:0]              clk_prev_ff;
  logic [7:0]                 q_ff;
  logic [7:0]                 bypass_ff;
  logic [3:0]                 five_input_mux_out_ff;
  logic [3:0]                 wide_function_mux_out_ff;
  logic                       carry_ff;
  logic                       ack_ff;
  logic [31:0]                dat_ff;

  logic                       run;
  logic                       cs_en;
  logic                       wb_req;
  logic                       wb_wr;
  logic [1:0]                 adr_slice;
  logic [3:0]                 adr_page;
  logic [31:0]                rd_mux;

  logic [NS-1:0]              clk_edge;
  logic [NS-1:0]              clk_level;
  logic [NS-1:0]              capture;
  logic                       mem_we;
  logic [NK-1:0]              mem_addr;
  logic [3:0]                 mem_data;
  logic [31:0]                lut_wr;

  cell_group_pkg::slice_out_t sout [NS];
  logic [NS:0]                carry;
  logic [7:0]                 f_all;

  assign run       = ctrl_ff[`CG_CTRL_RUN];
  assign cs_en     = ctrl_ff[`CG_CTRL_CS_EN];
  assign adr_slice = WB_ADR_I[3:2];
  assign adr_page  = WB_ADR_I[7:4];
  assign wb_req    = WB_CYC_I & WB_STB_I & ~ack_ff;
  assign wb_wr     = wb_req & WB_WE_I;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Applies the byte enables of a write to an old word.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Turns a memory request for a slice that has no writable memory into read-only memory.
  function automatic cell_group_pkg::slice_cfg_t fix_cfg(input int idx, input logic [31:0] w);
    cell_group_pkg::slice_cfg_t c;
    c = cell_group_pkg::slice_cfg_t'(w[`CG_CFG_WIDTH-1:0]);
    if (idx > `CG_RAM_LAST && c.mode == cell_group_pkg::MODE_RAM) begin
      c.mode = cell_group_pkg::MODE_ROM;
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, every address answered.

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      dat_ff <= 32'h0000_0000;
    end else if (wb_req) begin
      dat_ff <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if ({WB_ADR_I[7:2], 2'b00} == `CG_ADR_CTRL) begin
      rd_mux = ctrl_ff;
    end else if ({WB_ADR_I[7:2], 2'b00} == `CG_ADR_STATUS) begin
      rd_mux = {14'h0000, run, carry_ff, bypass_ff, q_ff};
    end else if (adr_page == `CG_PAGE_CFG) begin
      rd_mux = {25'h000_0000, cfg_ff[adr_slice]};
    end else if (adr_page == `CG_PAGE_LUT) begin
      rd_mux = {lut_ff[adr_slice][1], lut_ff[adr_slice][0]};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl_ff <= `CG_CTRL_RST;
    end else if (wb_wr && {WB_ADR_I[7:2], 2'b00} == `CG_ADR_CTRL) begin
      ctrl_ff <= merge_bytes(ctrl_ff, WB_DAT_I, WB_SEL_I);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      for (int s = 0; s < NS; s++) begin
        cfg_ff[s] <= cell_group_pkg::slice_cfg_t'(`CG_CFG_RST);
      end
    end else if (wb_wr && adr_page == `CG_PAGE_CFG) begin
      cfg_ff[adr_slice] <= fix_cfg(int'(adr_slice),
                                   merge_bytes({25'h000_0000, cfg_ff[adr_slice]}, WB_DAT_I, WB_SEL_I));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slice clocks: polarity select, edge or level capture.

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      clk_prev_ff <= 4'h0;
    end else begin
      clk_prev_ff <= SLICE_CLOCK;
    end
  end

  always_comb begin
    for (int s = 0; s < NS; s++) begin
      clk_edge[s]  = cfg_ff[s].clk_neg ? (clk_prev_ff[s] & ~SLICE_CLOCK[s])
                                       : (~clk_prev_ff[s] & SLICE_CLOCK[s]);
      clk_level[s] = SLICE_CLOCK[s] ^ cfg_ff[s].clk_neg;
      capture[s]   = cfg_ff[s].latch_en ? clk_level[s] : clk_edge[s];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Distributed memory controls generated by slice 2.

  assign mem_addr = SLICE_LUT_IN[`CG_MEM_CTRL*NI +: NK];
  assign mem_data = SLICE_LUT_IN[`CG_MEM_CTRL*NI+NK +: NK];
  assign mem_we   = run & clk_edge[`CG_MEM_CTRL] & LOCAL_SET_RESET[`CG_MEM_CTRL]
                  & (~cs_en | MULTIPURPOSE_IN[2*`CG_MEM_CTRL]);
  assign lut_wr   = merge_bytes({lut_ff[adr_slice][1], lut_ff[adr_slice][0]}, WB_DAT_I, WB_SEL_I);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      for (int s = 0; s < NS; s++) begin
        lut_ff[s][0] <= `CG_LUT_RST;
        lut_ff[s][1] <= `CG_LUT_RST;
      end
    end else begin
      if (wb_wr && adr_page == `CG_PAGE_LUT) begin
        lut_ff[adr_slice][0] <= lut_wr[15:0];
        lut_ff[adr_slice][1] <= lut_wr[31:16];
      end
      if (mem_we && cfg_ff[`CG_MEM_DATA_LO].mode == cell_group_pkg::MODE_RAM) begin
        lut_ff[`CG_MEM_DATA_LO][0][mem_addr] <= mem_data[0];
        lut_ff[`CG_MEM_DATA_LO][1][mem_addr] <= mem_data[1];
      end
      if (mem_we && cfg_ff[`CG_MEM_DATA_HI].mode == cell_group_pkg::MODE_RAM) begin
        lut_ff[`CG_MEM_DATA_HI][0][mem_addr] <= mem_data[2];
        lut_ff[`CG_MEM_DATA_HI][1][mem_addr] <= mem_data[3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lookup tables, ripple carry and wide-function multiplexers.

  always_comb begin
    logic [NK-1:0] a0;
    logic [NK-1:0] a1;
    logic          l0;
    logic          l1;
    logic          c_mid;
    a0       = '0;
    a1       = '0;
    l0       = 1'b0;
    l1       = 1'b0;
    c_mid    = 1'b0;
    carry[0] = CARRY_CHAIN_IN;
    for (int s = 0; s < NS; s++) begin
      a0 = SLICE_LUT_IN[s*NI +: NK];
      a1 = SLICE_LUT_IN[s*NI+NK +: NK];
      l0 = lut_ff[s][0][a0];
      l1 = lut_ff[s][1][a1];
      if (cfg_ff[s].mode == cell_group_pkg::MODE_RIPPLE) begin
        c_mid      = l0 ? carry[s] : a0[0];
        sout[s].f  = {l1 ^ c_mid, l0 ^ carry[s]};
        carry[s+1] = l1 ? c_mid : a1[0];
      end else begin
        sout[s].f  = {l1, l0};
        carry[s+1] = carry[s];
      end
      sout[s].five_input_mux_out = MULTIPURPOSE_IN[2*s] ? sout[s].f[1] : sout[s].f[0];
      sout[s].wide_function_mux_out = 1'b0;
    end
    sout[0].wide_function_mux_out = MULTIPURPOSE_IN[1] ? sout[1].five_input_mux_out : sout[0].five_input_mux_out;
    sout[2].wide_function_mux_out = MULTIPURPOSE_IN[5] ? sout[3].five_input_mux_out : sout[2].five_input_mux_out;
    sout[1].wide_function_mux_out = MULTIPURPOSE_IN[3] ? sout[2].wide_function_mux_out : sout[0].wide_function_mux_out;
    sout[3].wide_function_mux_out = MULTIPURPOSE_IN[7] ? CARRY_CHAIN_IN : sout[1].wide_function_mux_out;
    for (int s = 0; s < NS; s++) begin
      f_all[2*s +: 2] = sout[s].f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slice registers.

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      q_ff <= 8'h00;
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (!run) begin
          q_ff[2*s +: 2] <= cfg_ff[s].sr_val;
        end else if (LOCAL_SET_RESET[s] && (cfg_ff[s].sr_async || capture[s])) begin
          q_ff[2*s +: 2] <= cfg_ff[s].sr_val;
        end else if (SLICE_CLOCK_ENABLE[s] && capture[s]) begin
          q_ff[2*s +: 2] <= sout[s].f;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      bypass_ff <= 8'h00;
      five_input_mux_out_ff   <= 4'h0;
      wide_function_mux_out_ff   <= 4'h0;
      carry_ff  <= 1'b0;
    end else begin
      bypass_ff <= f_all;
      for (int s = 0; s < NS; s++) begin
        five_input_mux_out_ff[s] <= sout[s].five_input_mux_out;
        wide_function_mux_out_ff[s] <= sout[s].wide_function_mux_out;
      end
      carry_ff  <= carry[NS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs: 25 toward routing, all registered.

  assign WB_ACK_O              = ack_ff;
  assign WB_DAT_O              = dat_ff;
  assign LOOKUP_BYPASS_OUT     = bypass_ff;
  assign STORED_VALUE_OUT      = q_ff;
  assign FIVE_INPUT_MUX_OUT    = five_input_mux_out_ff;
  assign WIDE_FUNCTION_MUX_OUT = wide_function_mux_out_ff;
  assign CARRY_CHAIN_OUT       = carry_ff;

endmodule

// ===== test/cell_group_checker.sv
// Port checker of the logic cell group.
`timescale 1ns/1ns
module cell_group_checker (
  input wire logic        SYS_CLK,
  input wire logic        SYS_RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic [7:0]  MULTIPURPOSE_IN,
  input wire logic [3:0]  SLICE_CLOCK_ENABLE,
  input wire logic [3:0]  LOCAL_SET_RESET,
  input wire logic [7:0]  LOOKUP_BYPASS_OUT,
  input wire logic [7:0]  STORED_VALUE_OUT,
  input wire logic [3:0]  FIVE_INPUT_MUX_OUT,
  input wire logic        CARRY_CHAIN_OUT
);
  logic [7:0] hold_ff;
  logic [3:0] sel_ff;
  logic [3:0] lut5;
  wire logic  take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // Remembers which registers had neither enable nor set/reset.
  always_ff @(posedge SYS_CLK) begin
    for (int s = 0; s < 4; s++) begin
      hold_ff[2*s +: 2] <= {2{~SLICE_CLOCK_ENABLE[s] & ~LOCAL_SET_RESET[s]}};
      sel_ff[s] <= MULTIPURPOSE_IN[2*s];
    end
  end
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      lut5[s] = sel_ff[s] ? LOOKUP_BYPASS_OUT[2*s+1] : LOOKUP_BYPASS_OUT[2*s];
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_take; take; endsequence
  sequence s_answer; WB_ACK_O ##1 !WB_ACK_O; endsequence
  property p_ack; s_take |=> s_answer; endproperty
  property p_quiet; !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O; endproperty
  property p_dat; !take |=> $stable(WB_DAT_O); endproperty
  property p_unmapped;
    s_take ##0 (!WB_WE_I && (WB_ADR_I >= 8'h30 || WB_ADR_I[7:3] == 5'h01)) |=> WB_DAT_O == 32'h0;
  endproperty
  property p_status;
    s_take ##0 (!WB_WE_I && WB_ADR_I[7:2] == 6'h01) |=> WB_DAT_O[31:18] == 14'h0 &&
      WB_DAT_O[16:0] == {$past(CARRY_CHAIN_OUT), $past(LOOKUP_BYPASS_OUT), $past(STORED_VALUE_OUT)};
  endproperty
  property p_reset;
    $fell(SYS_RST) |-> {LOOKUP_BYPASS_OUT, STORED_VALUE_OUT, FIVE_INPUT_MUX_OUT, CARRY_CHAIN_OUT} == 21'h0;
  endproperty
  property p_hold; ((STORED_VALUE_OUT ^ $past(STORED_VALUE_OUT)) & hold_ff) == 8'h00; endproperty
  property p_lut5; FIVE_INPUT_MUX_OUT == lut5; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_quiet: assert property (p_quiet) else $error("ack without request");
  a_dat: assert property (p_dat) else $error("read data changed without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_status: assert property (p_status) else $error("status differs from outputs");
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  a_hold: assert property (p_hold) else $error("register changed while disabled");
  a_lut5: assert property (p_lut5) else $error("five input mux wrong");
endmodule
bind logic_slice_cluster cell_group_checker cell_group_checker_inst (
  .SYS_CLK            (SYS_CLK),
  .SYS_RST            (SYS_RST),
  .WB_CYC_I           (WB_CYC_I),
  .WB_STB_I           (WB_STB_I),
  .WB_WE_I            (WB_WE_I),
  .WB_ADR_I           (WB_ADR_I),
  .WB_DAT_O           (WB_DAT_O),
  .WB_ACK_O           (WB_ACK_O),
  .MULTIPURPOSE_IN    (MULTIPURPOSE_IN),
  .SLICE_CLOCK_ENABLE (SLICE_CLOCK_ENABLE),
  .LOCAL_SET_RESET    (LOCAL_SET_RESET),
  .LOOKUP_BYPASS_OUT  (LOOKUP_BYPASS_OUT),
  .STORED_VALUE_OUT   (STORED_VALUE_OUT),
  .FIVE_INPUT_MUX_OUT (FIVE_INPUT_MUX_OUT),
  .CARRY_CHAIN_OUT    (CARRY_CHAIN_OUT)
);

// ===== test/fabric_model.sv
// Neighbouring fabric: gated slice clocks and a carry from the adjacent group.
`timescale 1ns/1ns
module fabric_model (
  input  wire logic       clk,
  input  wire logic       run,
  output wire logic [3:0] slice_clock,
  output wire logic       carry
);
  logic [1:0] div_ff = 2'h0;
  // The slice clock stands still while run is low.
  always_ff @(posedge clk) begin
    if (run) begin
      div_ff <= div_ff + 2'h1;
    end
  end
  assign slice_clock = {4{div_ff[1]}};
  assign carry = div_ff[0];
endmodule

// ===== test/tb.sv
// Self-checking bench of the logic cell group.
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %0t got %h expected %h", $time, g, e); end end
module tb;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, run_clk = 0, ack, cin, cout;
  logic [7:0]  adr = 0, mp = 0, byp, q;
  logic [31:0] wd = 0, rdat, r, lut = 0;
  logic [3:0]  ce = 4'hf, local_set_reset = 0, sck, m5, mw;
  int          mismatches = 0, n_tests = 0, cycles = 0;
  row_t        rows [8] = '{'{8'h10, 32'h2, 32'h2}, '{8'h14, 32'h2, 32'h2}, '{8'h1c, 32'h2, 32'h3},
    '{8'h18, 32'h0, 32'h0}, '{8'h40, 32'h5a, 32'h0}, '{8'h04, 32'hff, 32'h0},
    '{8'h2c, 32'h0001_8000, 32'h0001_8000}, '{8'h00, 32'h1, 32'h1}};
  logic [31:0] cfgs [3] = '{32'h0, 32'h4, 32'h8};
  logic_slice_cluster logic_slice_cluster_inst (.SYS_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wd), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SLICE_LUT_IN(lut), .MULTIPURPOSE_IN(mp), .SLICE_CLOCK(sck), .SLICE_CLOCK_ENABLE(ce),
    .LOCAL_SET_RESET(local_set_reset), .CARRY_CHAIN_IN(cin), .LOOKUP_BYPASS_OUT(byp), .STORED_VALUE_OUT(q),
    .FIVE_INPUT_MUX_OUT(m5), .WIDE_FUNCTION_MUX_OUT(mw), .CARRY_CHAIN_OUT(cout));
  fabric_model fabric_model_inst (.clk(clk), .run(run_clk), .slice_clock(sck), .carry(cin));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    r = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  initial begin
    tick(20);
    rst <= 0;
    foreach (rows[i]) begin
      wb(1, rows[i].a, rows[i].d);
      wb(0, rows[i].a, 0);
      `CHK(r, rows[i].e)
    end
    run_clk <= 1;
    foreach (cfgs[j]) begin
      wb(1, 8'h1c, cfgs[j]);
      for (int i = 0; i < 2; i++) begin
        lut[31:24] <= i ? 8'h00 : 8'hff;
        mp[6] <= i;
        tick(8);
        `CHK(byp[7:6], i ? 2'b10 : 2'b01)
        `CHK(q[7:6], i ? 2'b10 : 2'b01)
      end
    end
    ce[3] <= 0;
    lut[31:24] <= 8'hff;
    tick(8);
    `CHK(q[7:6], 2'b10)
    for (int k = 0; k < 2; k++) begin
      wb(1, 8'h1c, k ? 32'h70 : 32'h60);
      ce[3] <= 1;
      run_clk <= 1;
      lut[31:24] <= 8'h00;
      tick(8);
      run_clk <= 0;
      tick(2);
      local_set_reset[3] <= 1;
      tick(6);
      `CHK(q[7:6], k ? 2'b11 : 2'b10)
      run_clk <= 1;
      tick(8);
      `CHK(q[7:6], 2'b11)
      local_set_reset[3] <= 0;
    end
    for (int k = 0; k < 3; k++) begin
      wb(1, 8'h00, k ? 32'h3 : 32'h1);
      mp[4] <= (k == 2);
      lut[23:16] <= k ? 8'hf6 : 8'hb5;
      local_set_reset[2] <= 1;
      tick(6);
      local_set_reset[2] <= 0;
      tick(2);
      wb(0, 8'h20, 0);
      `CHK(r, k == 2 ? 32'h0060_0060 : 32'h0020_0020)
    end
    wb(0, 8'h24, 0);
    `CHK(r, 32'h0060_0040)
    lut[15:0] <= 16'h5555;
    tick(3);
    `CHK(byp[3:0], 4'b1011)
    rst <= 1;
    run_clk <= 0;
    tick(3);
    rst <= 0;
    wb(0, 8'h20, 0);
    `CHK(r, 32'h0)
    `CHK(q, 8'h00)
    wb(1, 8'h10, 32'h1);
    wb(1, 8'h28, 32'h0000_ffff);
    lut[7:0] <= 8'h10;
    for (int k = 0; k < 2; k++) begin
      wb(1, 8'h20, k ? 32'hffff_ffff : 32'h0000_ffff);
      tick(2);
      `CHK(byp[1:0], {k ? ~cin : cin, ~cin})
      `CHK(cout, k ? cin : 1'b1)
    end
    mp <= 8'h08;
    tick(3);
    `CHK(mw, {3'b111, ~cin})
    mp <= 8'h28;
    tick(3);
    `CHK(mw, {3'b000, ~cin})
    mp <= 8'h80;
    tick(3);
    `CHK(mw, {cin, 1'b1, ~cin, ~cin})
    give_verdict();
  end
endmodule
